// File: ccdt_defines.vh
// Constants of the full-frame sensor timing generator.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef CCDT_DEFINES_VH
`define CCDT_DEFINES_VH
// Array geometry
`define CCDT_ACT_COLS      10'd512
`define CCDT_DARK_PRE      10'd4
`define CCDT_DARK_POST     10'd8
`define CCDT_LINE_PIX      10'd524
`define CCDT_ACT_ROWS      10'd512
`define CCDT_DARK_TOP      10'd4
`define CCDT_DARK_BOT      10'd4
`define CCDT_FRAME_LINES   10'd520
// Timing: one phase step in ns and derived core cycles
`define CCDT_CLK_NS        8
`define CCDT_STEP_NS       200
`define CCDT_STEP_CYC      ((`CCDT_STEP_NS + `CCDT_CLK_NS - 1) / `CCDT_CLK_NS)
`define CCDT_DIV_W         5
// Pixel tag codes
`define CCDT_TAG_ACTIVE    2'h0
`define CCDT_TAG_DARK_COL  2'h1
`define CCDT_TAG_DARK_ROW  2'h2
// Pixel buffer width
`define CCDT_DATA_W        16
`endif

// File: ccdt_skid.v
// Two-entry valid/ready buffer for sampled pixel words.
// Assumes one clock and synchronous handshakes on both sides.
`default_nettype none
module ccdt_skid (
  input  wire        i_core_clk, // Core clock
  input  wire        i_rst_n,    // Async reset, active low
  input  wire [17:0] i_data,     // Word in
  input  wire        i_valid,    // Word in valid
  output wire        o_ready,    // Space available
  output wire [17:0] o_data,     // Word out
  output wire        o_valid,    // Word out valid
  input  wire        i_ready     // Receiver ready
);
  reg  [17:0] mem_q [0:1];
  reg         wr_q;
  reg         rd_q;
  reg  [1:0]  cnt_q;
  wire        push;
  wire        pop;

  // Handshake terms
  assign push    = i_valid && (cnt_q != 2'h2);
  assign pop     = i_ready && (cnt_q != 2'h0);
  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rd_q];

  // Pointers and fill count
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= 18'h0;
      mem_q[1] <= 18'h0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= i_data;
        wr_q        <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: ccdt_timing_gen.v
// Timing generator driving a two-phase full-frame image sensor.
// Assumes pixel samples arrive from an external converter, synchronous.
// Behaviour
// - Shutter stays closed or strobe stays off during whole readout.
// - Wide-range output: second split gate blocked, first follows phase b.
// - Low-noise output: first split gate blocked, second follows phase b.
// - Pulse charge reset after each pixel sample, before next pixel.
// - Both vertical phases low throughout integration.
// - Line transfer starts with vertical phase a high.
// - Then reverse both vertical phases; phase b fall loads the line.
// - Second transition, then vertical phase a low ends the shift.
// - Read each line with complementary horizontal phases, one per pixel.
// - Repeat line shift plus horizontal readout for every frame line.
`include "ccdt_defines.vh"
`default_nettype none
module ccdt_timing_gen (
  input  wire        i_core_clk,         // 125 MHz core clock
  input  wire        i_rst_n,            // Async reset, active low
  input  wire        i_start,            // Begin one exposure and readout
  input  wire [15:0] i_expose_steps,     // Integration length in steps
  input  wire        i_low_noise_sel,    // 1 selects low-noise output
  input  wire [15:0] i_sample,           // Converter sample of a pixel
  input  wire        i_pix_ready,        // Receiver ready for pixels
  output reg         o_vertical_phase_a, // Vertical phase a drive
  output reg         o_vertical_phase_b, // Vertical phase b drive
  output reg         o_horizontal_phase_a, // Horizontal phase a drive
  output reg         o_horizontal_phase_b, // Horizontal phase b drive
  output reg         o_split_gate_first, // First split gate drive
  output reg         o_split_gate_second, // Second split gate drive
  output reg         o_charge_reset,     // Floating diffusion reset
  output reg         o_sample_strobe,    // Converter sample request
  output reg         o_shutter_open,     // Shutter / strobe enable
  output reg         o_busy,             // Frame in progress
  output reg  [15:0] o_pix_data,         // Buffered pixel sample
  output reg  [1:0]  o_pix_tag,          // Pixel class tag
  output reg         o_pix_valid         // Pixel word valid
);
  // One-hot states
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_EXPO  = 6'h02;
  localparam [5:0] S_VSHIFT = 6'h04;
  localparam [5:0] S_HCLK  = 6'h08;
  localparam [5:0] S_WAIT  = 6'h10;
  localparam [5:0] S_DONE  = 6'h20;

  reg  [5:0]  state_q;
  reg  [`CCDT_DIV_W-1:0] div_q;
  reg         step_q;
  reg  [15:0] exp_cnt_q;
  reg  [2:0]  vph_q;
  reg  [1:0]  hph_q;
  reg  [9:0]  col_q;
  reg  [9:0]  row_q;
  reg         lns_q;
  reg  [17:0] buf_in;
  reg         buf_push;
  wire        buf_ready;
  wire [17:0] buf_out;
  wire        buf_valid;
  wire        out_load;
  wire        hclk_step;
  wire        hb_next;

  // Classify a pixel by its column and row
  function [1:0] pix_class;
    input [9:0] col;
    input [9:0] row;
    begin
      if (row < `CCDT_DARK_TOP ||
          row >= (`CCDT_DARK_TOP + `CCDT_ACT_ROWS))
        pix_class = `CCDT_TAG_DARK_ROW;
      else if (col < `CCDT_DARK_PRE ||
               col >= (`CCDT_DARK_PRE + `CCDT_ACT_COLS))
        pix_class = `CCDT_TAG_DARK_COL;
      else
        pix_class = `CCDT_TAG_ACTIVE;
    end
  endfunction

  // Phase step enable divider
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_q  <= {`CCDT_DIV_W{1'b0}};
      step_q <= 1'b0;
    end
    else if (div_q == `CCDT_STEP_CYC - 1)
    begin
      div_q  <= {`CCDT_DIV_W{1'b0}};
      step_q <= 1'b1;
    end
    else
    begin
      div_q  <= div_q + {{(`CCDT_DIV_W-1){1'b0}}, 1'b1};
      step_q <= 1'b0;
    end
  end

  // Sequencer
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q              <= S_IDLE;
      exp_cnt_q            <= 16'h0;
      vph_q                <= 3'h0;
      hph_q                <= 2'h0;
      col_q                <= 10'h0;
      row_q                <= 10'h0;
      o_vertical_phase_a   <= 1'b0;
      o_vertical_phase_b   <= 1'b0;
      o_horizontal_phase_a <= 1'b1;
      o_horizontal_phase_b <= 1'b0;
      o_charge_reset       <= 1'b0;
      o_sample_strobe      <= 1'b0;
      o_shutter_open       <= 1'b0;
      o_busy               <= 1'b0;
    end
    else
    begin
      o_sample_strobe <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (i_start)
          begin
            state_q        <= S_EXPO;
            exp_cnt_q      <= i_expose_steps;
            o_busy         <= 1'b1;
            o_shutter_open <= 1'b1;
            row_q          <= 10'h0;
          end
        end
        S_EXPO:
        begin
          o_vertical_phase_a <= 1'b0;
          o_vertical_phase_b <= 1'b0;
          if (step_q)
          begin
            if (exp_cnt_q == 16'h0)
            begin
              o_shutter_open <= 1'b0;
              state_q        <= S_VSHIFT;
              vph_q          <= 3'h0;
            end
            else
              exp_cnt_q <= exp_cnt_q - 16'h1;
          end
        end
        S_VSHIFT:
        begin
          if (step_q)
          begin
            vph_q <= vph_q + 3'h1;
            case (vph_q)
              3'h0: o_vertical_phase_a <= 1'b1;
              3'h1:
              begin
                o_vertical_phase_a <= 1'b0;
                o_vertical_phase_b <= 1'b1;
              end
              3'h2:
              begin
                o_vertical_phase_a <= 1'b1;
                o_vertical_phase_b <= 1'b0;
              end
              3'h3:
              begin
                o_vertical_phase_a <= 1'b0;
                state_q            <= S_HCLK;
                hph_q              <= 2'h0;
                col_q              <= 10'h0;
              end
              default: vph_q <= 3'h0;
            endcase
          end
        end
        S_HCLK:
        begin
          if (step_q)
          begin
            hph_q <= hph_q + 2'h1;
            case (hph_q)
              2'h0:
              begin
                o_horizontal_phase_a <= 1'b0;
                o_horizontal_phase_b <= 1'b1;
              end
              // phase b fall dumps a packet
              2'h1:
              begin
                o_horizontal_phase_a <= 1'b1;
                o_horizontal_phase_b <= 1'b0;
              end
              2'h2: o_sample_strobe <= 1'b1;
              2'h3:
              begin
                o_charge_reset <= 1'b1;
                state_q        <= S_WAIT;
              end
              default: hph_q <= 2'h0;
            endcase
          end
        end
        // Finish reset pulse and stall on full buffer
        S_WAIT:
        begin
          if (step_q && buf_ready)
          begin
            o_charge_reset <= 1'b0;
            hph_q          <= 2'h0;
            if (col_q == `CCDT_LINE_PIX - 10'h1)
            begin
              if (row_q == `CCDT_FRAME_LINES - 10'h1)
                state_q <= S_DONE;
              else
              begin
                row_q   <= row_q + 10'h1;
                vph_q   <= 3'h0;
                state_q <= S_VSHIFT;
              end
            end
            else
            begin
              col_q   <= col_q + 10'h1;
              state_q <= S_HCLK;
            end
          end
        end
        S_DONE:
        begin
          o_busy  <= 1'b0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Next value of phase b, so split gates switch with it
  assign hclk_step = (state_q == S_HCLK) && step_q;
  assign hb_next   = (hclk_step && hph_q == 2'h0) ? 1'b1 :
                     (hclk_step && hph_q == 2'h1) ? 1'b0 :
                     o_horizontal_phase_b;

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_split_gate_first  <= 1'b0;
      o_split_gate_second <= 1'b0;
      lns_q               <= 1'b0;
    end
    else
    begin
      if (!o_busy)
        lns_q <= i_low_noise_sel;
      o_split_gate_first  <= lns_q ? 1'b0 : hb_next;
      o_split_gate_second <= lns_q ? hb_next : 1'b0;
    end
  end

  always @*
  begin
    buf_push = o_sample_strobe;
    buf_in   = {pix_class(col_q, row_q), i_sample};
  end

  // Output stage takes a word when empty or being handed over
  assign out_load = !o_pix_valid || i_pix_ready;

  ccdt_skid u_skid (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_data     (buf_in),
    .i_valid    (buf_push),
    .o_ready    (buf_ready),
    .o_data     (buf_out),
    .o_valid    (buf_valid),
    .i_ready    (out_load)
  );

  // Output register holds each word until it is taken
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pix_data  <= 16'h0;
      o_pix_tag   <= 2'h0;
      o_pix_valid <= 1'b0;
    end
    else if (out_load)
    begin
      o_pix_data  <= buf_out[15:0];
      o_pix_tag   <= buf_out[17:16];
      o_pix_valid <= buf_valid;
    end
  end
endmodule
`default_nettype wire

// File: ccdt_monitor.sv
// Port checker for the sensor timing generator.
// Bound to ccdt_timing_gen; watches its ports only.
`default_nettype none
module ccdt_mon (
  input wire logic i_core_clk,           // Clock
  input wire logic i_rst_n,              // Reset, low
  input wire logic i_low_noise_sel,      // Output select
  input wire logic i_pix_ready,          // Receiver ready
  input wire logic o_vertical_phase_a,   // Va
  input wire logic o_vertical_phase_b,   // Vb
  input wire logic o_horizontal_phase_a, // Ha
  input wire logic o_horizontal_phase_b, // Hb
  input wire logic o_split_gate_first,   // Gate 1
  input wire logic o_split_gate_second,  // Gate 2
  input wire logic o_charge_reset,       // Node reset
  input wire logic o_sample_strobe,      // Sample pulse
  input wire logic o_shutter_open,       // Exposure
  input wire logic o_busy,               // Frame busy
  input wire logic o_pix_valid           // Word valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Short aliases
  wire va = o_vertical_phase_a;
  wire vb = o_vertical_phase_b;
  wire ha = o_horizontal_phase_a;
  wire hb = o_horizontal_phase_b;
  wire g1 = o_split_gate_first;
  wire g2 = o_split_gate_second;
  logic busy_q;
  // Busy as seen one cycle earlier
  always @(posedge i_core_clk)
    busy_q <= o_busy;
  wire on = o_busy && busy_q;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Phase relations
  chk_expose_v_low: assert property (o_shutter_open |-> !va && !vb)
    else $error("vertical phase high in exposure");
  chk_shut_read: assert property (va || o_sample_strobe |-> !o_shutter_open)
    else $error("shutter open in readout");
  chk_v_no_overlap: assert property (!(va && vb))
    else $error("vertical phases both high");
  chk_v_reverse: assert property ($rose(vb) |-> $fell(va))
    else $error("vertical phases not reversed");
  chk_v_return: assert property ($fell(vb) |-> $rose(va) ##1 va [*8]
    ##[1:40] !va) else $error("shift not ended by phase a low");
  chk_h_compl: assert property (ha != hb)
    else $error("horizontal phases not complementary");
  chk_h_static: assert property ((va || vb) && $past(va || vb)
    |-> $stable(hb) && !o_sample_strobe) else $error("h moved in shift");
  chk_gate_wide: assert property (on && !i_low_noise_sel
    |-> !g2 && g1 == hb) else $error("wide output gate wrong");
  chk_gate_low: assert property (on && i_low_noise_sel
    |-> !g1 && g2 == hb) else $error("low noise gate wrong");
  chk_reset_pulse: assert property (o_sample_strobe |-> ##[1:60]
    o_charge_reset) else $error("no charge reset after sample");
  chk_reset_clear: assert property ($fell(hb) |-> !o_charge_reset)
    else $error("charge reset high at packet");
  // Main scenarios
  cov_expose: cover property (o_shutter_open);
  cov_line: cover property ($fell(vb));
  cov_word: cover property (o_pix_valid && i_pix_ready);
  cov_low: cover property (o_busy && i_low_noise_sel);
endmodule
bind ccdt_timing_gen ccdt_mon u_mon (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_low_noise_sel(i_low_noise_sel), .i_pix_ready(i_pix_ready),
  .o_vertical_phase_a(o_vertical_phase_a),
  .o_vertical_phase_b(o_vertical_phase_b),
  .o_horizontal_phase_a(o_horizontal_phase_a),
  .o_horizontal_phase_b(o_horizontal_phase_b),
  .o_split_gate_first(o_split_gate_first),
  .o_split_gate_second(o_split_gate_second),
  .o_charge_reset(o_charge_reset), .o_sample_strobe(o_sample_strobe),
  .o_shutter_open(o_shutter_open), .o_busy(o_busy),
  .o_pix_valid(o_pix_valid)
);
`default_nettype wire

// File: ccdt_sensor_model.sv
// Behavioural sensor: codes each packet by row and column.
// Assumes phase pins are sampled on the core clock.
`default_nettype none
module ccdt_sensor_model (
  input  wire logic        i_core_clk, // Sampling clock
  input  wire logic        i_shutter,  // Exposure active
  input  wire logic        i_vphase_b, // Vertical phase b
  input  wire logic        i_hphase_b, // Horizontal phase b
  output var  logic [15:0] o_sample    // Packet code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] row_q;
  logic [9:0] col_q;
  logic       vb_q;
  logic       hb_q;
  // Line and packet transport
  always @(posedge i_core_clk)
  begin
    vb_q <= i_vphase_b;
    hb_q <= i_hphase_b;
    if (i_shutter)
      row_q <= 10'h3ff;
    // phase b fall loads one line
    else if (vb_q && !i_vphase_b)
    begin
      row_q <= row_q + 10'h001;
      col_q <= 10'h000;
    end
    // phase b fall pushes one packet
    if (hb_q && !i_hphase_b)
    begin
      o_sample <= {row_q[5:0], col_q};
      col_q    <= col_q + 10'h001;
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// Bench for the timing generator with a sensor model.
// Assumes nothing outside; clock and stimulus made here.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_rst_n, i_start, sel, i_pix_ready;
  logic [15:0] expo, smp, pd;
  logic va, vb, ha, hb, g1, g2, cr, stb, shut, busy, pv, hb_d, vb_d;
  logic [1:0] pt;
  logic [17:0] exp_q[$];
  int fail_count, total_checks, got, need, hfall, stall;
  ccdt_timing_gen u_dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_start(i_start),
    .i_expose_steps(expo), .i_low_noise_sel(sel), .i_sample(smp),
    .i_pix_ready(i_pix_ready), .o_vertical_phase_a(va),
    .o_vertical_phase_b(vb), .o_horizontal_phase_a(ha),
    .o_horizontal_phase_b(hb), .o_split_gate_first(g1),
    .o_split_gate_second(g2), .o_charge_reset(cr),
    .o_sample_strobe(stb), .o_shutter_open(shut), .o_busy(busy),
    .o_pix_data(pd), .o_pix_tag(pt), .o_pix_valid(pv));
  ccdt_sensor_model u_model (.i_core_clk(i_core_clk), .i_shutter(shut),
    .i_vphase_b(vb), .i_hphase_b(hb), .o_sample(smp));
  // Compare and count
  task automatic check(string name, logic [17:0] seen, logic [17:0] ex);
    total_checks++;
    if (seen !== ex)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, ex, seen);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Clock
  initial
  begin
    i_core_clk = 0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  // Receiver: take oldest note per word, count pixel cycles
  always @(posedge i_core_clk)
  begin
    hb_d <= hb;
    vb_d <= vb;
    if (vb_d && !vb)
      hfall = 0;
    else if (hb_d && !hb)
      hfall++;
    if (pv && i_pix_ready)
    begin
      got++;
      i_pix_ready <= 0;
      if (exp_q.size() == 0)
        check("extra word", {pt, pd}, 18'h0);
      else
        check("pixel word", {pt, pd}, exp_q.pop_front());
    end
    else
      i_pix_ready <= (got < need && stall == 0) ? 1'($urandom_range(1)) : 0;
  end
  // One frame start, stall, collect n words, then reset
  task automatic run(logic s, int n);
    int k;
    int h0;
    sel <= s;
    expo <= 16'($urandom_range(3));
    got = 0;
    need = n;
    for (k = 0; k < n; k++)
      exp_q.push_back({2'h2, 6'h00, 10'(k)});
    @(posedge i_core_clk);
    i_start <= 1;
    @(posedge i_core_clk);
    i_start <= 0;
    stall = 1;
    repeat (2000) @(posedge i_core_clk);
    #1 check("busy", 18'(busy), 18'h1);
    h0 = hfall;
    repeat (1000) @(posedge i_core_clk);
    check("stalled clocking", 18'(hfall), 18'(h0));
    stall = 0;
    // A full line is 524 pixels of 125 cycles each
    for (k = 0; k < 70000 && got < n; k++)
      @(posedge i_core_clk);
    check("words", 18'(got), 18'(n));
    check("queue left", 18'(exp_q.size()), 18'h0);
    if (n == 524)
      check("pixel cycles", 18'(hfall), 18'(n));
    i_rst_n <= 0;
    @(posedge i_core_clk);
    i_rst_n <= 1;
  endtask
  // Watchdog
  initial
  begin
    #720000;
    fail_count++;
    summarize();
  end
  // Main sequence
  initial
  begin
    i_rst_n = 0;
    i_start = 0;
    sel = 0;
    expo = 0;
    i_pix_ready = 0;
    fail_count = 0;
    total_checks = 0;
    got = 0;
    need = 0;
    hfall = 0;
    stall = 0;
    void'($urandom(69));
    repeat (5) @(posedge i_core_clk);
    check("reset phase a", 18'(ha), 18'h1);
    i_rst_n <= 1;
    run(1'b0, 524);
    run(1'b1, 20);
    summarize();
  end
endmodule
`default_nettype wire
